// ===== design/fmcd_decoder.sv
// Operation
// R1: Single bits writable and readable via bit ports
// R2: Command byte: run1, run2, remote, reset, trip
// R3: Codes 1-3: clear queue, snapshot, test trip
// R4: Service code zero does nothing
// R5: Codes 4-8: repair, factory, soft, fault, proof
// R6: Field word bits 0,1 drive outputs 1,2
// R7: Bit 2 drives output 3 or sets latch
// R8: Bit 3 resets latch only with option
// R9: Status byte carries eight motor flags
// R10: Selectable readable status and code words
// R11: Status bit order running1 first, at-speed bit7
// R12: Reserved bits and codes above eight ignored
`timescale 1ns/1ns
`default_nettype none

module fmcd_decoder (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Word writes from the fieldbus side
  input wire logic i_mcb_wr,
  input wire logic [7:0] i_mcb_data,
  input wire logic i_svc_wr,
  input wire logic [15:0] i_svc_data,
  input wire logic i_fow_wr,
  input wire logic [15:0] i_fow_data,
  // Single-bit writes
  input wire logic i_bit_wr,
  input wire logic [3:0] i_bit_index,
  input wire logic i_bit_value,
  // Readback selection
  input wire logic [1:0] i_read_sel,
  input wire logic [2:0] i_read_bit,
  // Relay protection side
  input wire fmcd_pkg::fmcd_status_t i_status,
  input wire fmcd_pkg::fmcd_codes_t i_codes,
  input wire logic i_latch_option,
  // Motor actions
  output logic o_run1,
  output logic o_run2,
  output logic o_remote,
  output logic o_fault_reset,
  output logic o_test_trip,
  output fmcd_pkg::fmcd_service_t o_service,
  // Base control module outputs
  output logic [2:0] o_field_out,
  // Readback
  output logic [7:0] o_status_byte,
  output logic [15:0] o_read_word,
  output logic o_read_bit
);

  // ****************************************
  // Stored command words
  // ****************************************
  logic [7:0] motor_command_byte;
  logic [15:0] service_command_word;
  logic [15:0] field_output_word;
  logic [7:0] next_mcb;
  logic [15:0] next_fow;
  logic svc_fresh;

  wire logic bit_mcb = i_bit_wr && (i_bit_index < fmcd_pkg::BIT_FOW_BASE);
  wire logic bit_fow = i_bit_wr && (i_bit_index >= fmcd_pkg::BIT_FOW_BASE)
                       && (i_bit_index <= fmcd_pkg::BIT_LAST);
  wire logic [2:0] mcb_idx = i_bit_index[2:0];
  wire logic [1:0] fow_idx = 2'(i_bit_index - fmcd_pkg::BIT_FOW_BASE);

  always_comb begin
    next_mcb = motor_command_byte;
    if (i_mcb_wr) begin
      next_mcb = i_mcb_data & fmcd_pkg::MCB_USED_MASK; // R12
    end else if (bit_mcb && fmcd_pkg::MCB_USED_MASK[mcb_idx]) begin
      next_mcb[mcb_idx] = i_bit_value; // R1
    end
  end

  always_comb begin
    next_fow = field_output_word;
    if (i_fow_wr) begin
      next_fow = i_fow_data;
    end else if (bit_fow) begin
      next_fow[fow_idx] = i_bit_value; // R1
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      motor_command_byte <= fmcd_pkg::MCB_RESET;
      field_output_word <= fmcd_pkg::FOW_RESET;
      service_command_word <= fmcd_pkg::SVC_NONE;
      svc_fresh <= 1'b0;
    end else if (i_ce) begin
      motor_command_byte <= next_mcb;
      field_output_word <= next_fow;
      svc_fresh <= i_svc_wr;
      if (i_svc_wr) begin
        service_command_word <= i_svc_data;
      end
    end
  end

  // ****************************************
  // Motor command byte actions
  // ****************************************
  logic [7:0] mcb_rise;

  fmcd_edge #(
    .WIDTH(8)
  ) u_mcb_edge (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_level(motor_command_byte),
    .o_rise(mcb_rise)
  );

  // ****************************************
  // Service code decode
  // ****************************************
  wire logic svc_act = svc_fresh && i_ce;
  wire logic [15:0] svc = service_command_word;
  wire fmcd_pkg::fmcd_service_t svc_dec = '{
    clear_fault_queue: svc_act && (svc == fmcd_pkg::SVC_CLEAR_FAULT_QUEUE), // R3
    clear_snapshot: svc_act && (svc == fmcd_pkg::SVC_CLEAR_SNAPSHOT), // R3
    test_trip: svc_act && (svc == fmcd_pkg::SVC_TEST_TRIP), // R3
    repair_modules: svc_act && (svc == fmcd_pkg::SVC_REPAIR_MODULES), // R5
    factory_reset: svc_act && (svc == fmcd_pkg::SVC_FACTORY_RESET), // R5
    soft_reset: svc_act && (svc == fmcd_pkg::SVC_SOFT_RESET), // R5
    reset_fault: svc_act && (svc == fmcd_pkg::SVC_RESET_FAULT), // R5
    proof_test: svc_act && (svc == fmcd_pkg::SVC_PROOF_TEST) // R5
  };
  // Zero and codes above eight match no entry, so nothing fires
  // R4 R12

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_run1 <= 1'b0;
      o_run2 <= 1'b0;
      o_remote <= 1'b0;
      o_fault_reset <= 1'b0;
      o_test_trip <= 1'b0;
      o_service <= '0;
    end else if (i_ce) begin
      o_run1 <= motor_command_byte[fmcd_pkg::MCB_RUN1]; // R2
      o_run2 <= motor_command_byte[fmcd_pkg::MCB_RUN2]; // R2
      o_remote <= motor_command_byte[fmcd_pkg::MCB_REMOTE]; // R2
      o_fault_reset <= mcb_rise[fmcd_pkg::MCB_FAULT_RESET] || svc_dec.reset_fault; // R2
      o_test_trip <= mcb_rise[fmcd_pkg::MCB_TEST_TRIP] || svc_dec.test_trip; // R2
      o_service <= svc_dec;
    end
  end

  // ****************************************
  // Base control module outputs
  // ****************************************
  logic latch_state;
  wire logic fo_set = field_output_word[fmcd_pkg::FOW_OUT3_SET];
  wire logic fo_clr = field_output_word[fmcd_pkg::FOW_LATCH_RESET] && i_latch_option; // R8
  wire logic out3 = i_latch_option ? latch_state : fo_set; // R7

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      latch_state <= 1'b0;
      o_field_out <= 3'h0;
    end else if (i_ce) begin
      // Latch moves only with the option fitted, so no stale state shows later
      if (i_latch_option && fo_set && !fo_clr) begin
        latch_state <= 1'b1; // R7
      end else if (fo_clr && !fo_set) begin
        latch_state <= 1'b0; // R8
      end
      o_field_out <= {out3,
                      field_output_word[fmcd_pkg::FOW_OUT2],
                      field_output_word[fmcd_pkg::FOW_OUT1]}; // R6
    end
  end

  // ****************************************
  // Readback
  // ****************************************
  wire logic [7:0] status_now = i_status; // R9 R11
  wire logic [15:0] read_mux =
    (i_read_sel == fmcd_pkg::RSEL_STATUS) ? {8'h00, status_now} :
    (i_read_sel == fmcd_pkg::RSEL_FAULT) ? i_codes.fault :
    (i_read_sel == fmcd_pkg::RSEL_INHIBIT) ? i_codes.inhibit :
    i_codes.warning; // R10

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_status_byte <= fmcd_pkg::STATUS_RESET;
      o_read_word <= 16'h0000;
      o_read_bit <= 1'b0;
    end else if (i_ce) begin
      o_status_byte <= status_now; // R9
      o_read_word <= read_mux; // R10
      o_read_bit <= status_now[i_read_bit]; // R1
    end
  end

endmodule : fmcd_decoder

`default_nettype wire

// ===== design/fmcd_edge.sv
`timescale 1ns/1ns
`default_nettype none

module fmcd_edge #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Level in, rising-edge pulse out
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_rise
);

  logic [WIDTH-1:0] prev;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prev <= '0;
    end else if (i_ce) begin
      prev <= i_level;
    end
  end

  assign o_rise = i_level & ~prev & {WIDTH{i_ce}};

endmodule : fmcd_edge

`default_nettype wire

// ===== design/fmcd_pkg.sv
package fmcd_pkg;

  // ****************************************
  // Motor command byte fields
  // ****************************************
  localparam int MCB_RUN1 = 0;
  localparam int MCB_RUN2 = 1;
  localparam int MCB_REMOTE = 2;
  localparam int MCB_FAULT_RESET = 3;
  localparam int MCB_TEST_TRIP = 5;
  localparam logic [7:0] MCB_USED_MASK = 8'h2F;
  localparam logic [7:0] MCB_RESET = 8'h00;

  // ****************************************
  // Service command codes
  // ****************************************
  localparam logic [15:0] SVC_NONE = 16'h0000;
  localparam logic [15:0] SVC_CLEAR_FAULT_QUEUE = 16'h0001;
  localparam logic [15:0] SVC_CLEAR_SNAPSHOT = 16'h0002;
  localparam logic [15:0] SVC_TEST_TRIP = 16'h0003;
  localparam logic [15:0] SVC_REPAIR_MODULES = 16'h0004;
  localparam logic [15:0] SVC_FACTORY_RESET = 16'h0005;
  localparam logic [15:0] SVC_SOFT_RESET = 16'h0006;
  localparam logic [15:0] SVC_RESET_FAULT = 16'h0007;
  localparam logic [15:0] SVC_PROOF_TEST = 16'h0008;
  localparam int SVC_COUNT = 8;

  // ****************************************
  // Field output word fields
  // ****************************************
  localparam int FOW_OUT1 = 0;
  localparam int FOW_OUT2 = 1;
  localparam int FOW_OUT3_SET = 2;
  localparam int FOW_LATCH_RESET = 3;
  localparam logic [15:0] FOW_RESET = 16'h0000;

  // ****************************************
  // Bit-mapped write indices
  // ****************************************
  localparam logic [3:0] BIT_FOW_BASE = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'hB;

  // ****************************************
  // Readable word selections
  // ****************************************
  localparam logic [1:0] RSEL_STATUS = 2'h0;
  localparam logic [1:0] RSEL_FAULT = 2'h1;
  localparam logic [1:0] RSEL_INHIBIT = 2'h2;
  localparam logic [1:0] RSEL_WARNING = 2'h3;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic at_speed;
    logic ready;
    logic inhibited;
    logic warning;
    logic faulted;
    logic remote;
    logic running2;
    logic running1;
  } fmcd_status_t;

  typedef struct packed {
    logic [15:0] warning;
    logic [15:0] inhibit;
    logic [15:0] fault;
  } fmcd_codes_t;

  typedef struct packed {
    logic proof_test;
    logic reset_fault;
    logic soft_reset;
    logic factory_reset;
    logic repair_modules;
    logic test_trip;
    logic clear_snapshot;
    logic clear_fault_queue;
  } fmcd_service_t;

endpackage : fmcd_pkg

// ===== tb/fmcd_chk.sv
`timescale 1ns/1ns
`default_nettype none

module fmcd_chk (
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_mcb_wr,
  input wire logic [7:0] i_mcb_data,
  input wire logic i_svc_wr,
  input wire logic [15:0] i_svc_data,
  input wire logic i_fow_wr,
  input wire logic [15:0] i_fow_data,
  input wire fmcd_pkg::fmcd_status_t i_status,
  input wire logic i_latch_option,
  input wire logic o_run1,
  input wire logic o_run2,
  input wire logic o_remote,
  input wire logic o_fault_reset,
  input wire logic o_test_trip,
  input wire fmcd_pkg::fmcd_service_t o_service,
  input wire logic [2:0] o_field_out,
  input wire logic [7:0] o_status_byte
);
  wire logic [7:0] svc_hot = 8'h01 << (i_svc_data[3:0] - 4'h1);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_svc(logic [15:0] c);
    i_ce && i_svc_wr && i_svc_data == c;
  endsequence
  sequence s_latch(logic [1:0] sr);
    i_ce && i_fow_wr && i_latch_option && i_fow_data[3:2] == sr ##1 i_latch_option [*2];
  endsequence

  svc_hot_a: assert property (i_ce && i_svc_wr && i_svc_data inside {[1:8]}
    |-> ##2 o_service == $past(svc_hot, 2)) else $error("service pulse wrong");
  svc_idle_a: assert property (o_service != 8'h00
    |-> $past(i_svc_wr, 2) && $past(i_svc_data, 2) inside {[1:8]}) else $error("stray service");
  test_trip_a: assert property (s_svc(fmcd_pkg::SVC_TEST_TRIP)
    |-> ##2 o_test_trip && o_service.test_trip) else $error("no test trip");
  fault_reset_a: assert property (s_svc(fmcd_pkg::SVC_RESET_FAULT)
    |-> ##2 o_fault_reset && o_service.reset_fault) else $error("no fault reset");
  run_level_a: assert property (i_ce && i_mcb_wr
    |-> ##2 {o_remote, o_run2, o_run1} == $past(i_mcb_data[2:0], 2)) else $error("run levels");
  field_low_a: assert property (i_ce && i_fow_wr
    |-> ##2 o_field_out[1:0] == $past(i_fow_data[1:0], 2)) else $error("field outputs");
  latch_set_a: assert property (s_latch(2'b01) |=> o_field_out[2])
    else $error("latch not set");
  latch_clr_a: assert property (s_latch(2'b10) |=> !o_field_out[2])
    else $error("latch not reset");
  status_copy_a: assert property (!$past(i_rst) && $past(i_ce)
    |-> o_status_byte == $past(i_status)) else $error("status byte");
endmodule : fmcd_chk

bind fmcd_decoder fmcd_chk fmcd_chk_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
  .i_mcb_wr(i_mcb_wr), .i_mcb_data(i_mcb_data), .i_svc_wr(i_svc_wr), .i_svc_data(i_svc_data),
  .i_fow_wr(i_fow_wr), .i_fow_data(i_fow_data), .i_status(i_status),
  .i_latch_option(i_latch_option), .o_run1(o_run1), .o_run2(o_run2), .o_remote(o_remote),
  .o_fault_reset(o_fault_reset), .o_test_trip(o_test_trip), .o_service(o_service),
  .o_field_out(o_field_out), .o_status_byte(o_status_byte));

`default_nettype wire

// ===== tb/fmcd_master.sv
`timescale 1ns/1ns
`default_nettype none

module fmcd_master (
  // Clock
  input wire logic i_mclk,
  // Word and bit writes
  output logic o_mcb_wr,
  output logic [7:0] o_mcb_data,
  output logic o_svc_wr,
  output logic [15:0] o_svc_data,
  output logic o_fow_wr,
  output logic [15:0] o_fow_data,
  output logic o_bit_wr,
  output logic o_bit_value,
  output logic [3:0] o_bit_index
);
  initial {o_mcb_wr, o_svc_wr, o_fow_wr, o_bit_wr} = 4'h0;
  initial {o_mcb_data, o_svc_data, o_fow_data, o_bit_value, o_bit_index} = '0;

  // Strobe for one edge; released word data is inverted, bit value and index are left as driven
  task automatic put(input logic [1:0] k, input logic [15:0] d);
    @(negedge i_mclk);
    case (k)
      2'h0: {o_mcb_wr, o_mcb_data} = {1'b1, d[7:0]};
      2'h1: {o_svc_wr, o_svc_data} = {1'b1, d};
      2'h2: {o_fow_wr, o_fow_data} = {1'b1, d};
      default: {o_bit_wr, o_bit_value, o_bit_index} = {1'b1, d[4:0]};
    endcase
    @(negedge i_mclk);
    {o_mcb_wr, o_svc_wr, o_fow_wr, o_bit_wr} = 4'h0;
    {o_mcb_data, o_svc_data, o_fow_data} = ~{o_mcb_data, o_svc_data, o_fow_data};
  endtask : put
endmodule : fmcd_master

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  typedef struct packed {
    logic [1:0] k;
    logic [15:0] d;
    logic [7:0] svc;
    logic [1:0] tf;
    logic [2:0] run;
    logic [2:0] fo;
  } fmcd_row_t;
  logic i_mclk, i_rst, i_mcb_wr, i_svc_wr, i_fow_wr, i_bit_wr, i_bit_value, i_latch_option;
  logic i_ce = 1'b1;
  logic [7:0] i_mcb_data;
  logic [15:0] i_svc_data, i_fow_data;
  logic [3:0] i_bit_index;
  logic [1:0] i_read_sel;
  logic [2:0] i_read_bit;
  fmcd_pkg::fmcd_status_t i_status;
  fmcd_pkg::fmcd_codes_t i_codes;
  logic o_run1, o_run2, o_remote, o_fault_reset, o_test_trip, o_read_bit;
  fmcd_pkg::fmcd_service_t o_service;
  logic [2:0] o_field_out;
  logic [7:0] o_status_byte;
  logic [15:0] o_read_word;
  int num_errors, total_checks;
  // Kind, data, service, trip and fault reset, run levels, field outputs
  fmcd_row_t rows [15] = '{
    '{2'h0, 16'h00D7, 8'h00, 2'h0, 3'h7, 3'h0}, '{2'h0, 16'h0028, 8'h00, 2'h3, 3'h0, 3'h0},
    '{2'h1, 16'h0000, 8'h00, 2'h0, 3'h0, 3'h0}, '{2'h1, 16'h0001, 8'h01, 2'h0, 3'h0, 3'h0},
    '{2'h1, 16'h0002, 8'h02, 2'h0, 3'h0, 3'h0}, '{2'h1, 16'h0003, 8'h04, 2'h2, 3'h0, 3'h0},
    '{2'h1, 16'h0004, 8'h08, 2'h0, 3'h0, 3'h0}, '{2'h1, 16'h0005, 8'h10, 2'h0, 3'h0, 3'h0},
    '{2'h1, 16'h0006, 8'h20, 2'h0, 3'h0, 3'h0}, '{2'h1, 16'h0007, 8'h40, 2'h1, 3'h0, 3'h0},
    '{2'h1, 16'h0008, 8'h80, 2'h0, 3'h0, 3'h0}, '{2'h1, 16'h0009, 8'h00, 2'h0, 3'h0, 3'h0},
    '{2'h2, 16'h0007, 8'h00, 2'h0, 3'h0, 3'h7}, '{2'h2, 16'hFFFF, 8'h00, 2'h0, 3'h0, 3'h7},
    '{2'h2, 16'h0000, 8'h00, 2'h0, 3'h0, 3'h0}};

  fmcd_decoder fmcd_decoder_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
    .i_mcb_wr(i_mcb_wr), .i_mcb_data(i_mcb_data), .i_svc_wr(i_svc_wr), .i_svc_data(i_svc_data),
    .i_fow_wr(i_fow_wr), .i_fow_data(i_fow_data), .i_bit_wr(i_bit_wr), .i_bit_index(i_bit_index),
    .i_bit_value(i_bit_value), .i_read_sel(i_read_sel), .i_read_bit(i_read_bit),
    .i_status(i_status), .i_codes(i_codes), .i_latch_option(i_latch_option),
    .o_run1(o_run1), .o_run2(o_run2), .o_remote(o_remote), .o_fault_reset(o_fault_reset),
    .o_test_trip(o_test_trip), .o_service(o_service), .o_field_out(o_field_out),
    .o_status_byte(o_status_byte), .o_read_word(o_read_word), .o_read_bit(o_read_bit));
  fmcd_master fmcd_master_inst (.i_mclk(i_mclk), .o_mcb_wr(i_mcb_wr), .o_mcb_data(i_mcb_data),
    .o_svc_wr(i_svc_wr), .o_svc_data(i_svc_data), .o_fow_wr(i_fow_wr), .o_fow_data(i_fow_data),
    .o_bit_wr(i_bit_wr), .o_bit_value(i_bit_value), .o_bit_index(i_bit_index));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic go(input logic [1:0] k, input logic [15:0] d, input int n);
    fmcd_master_inst.put(k, d);
    repeat (n) @(negedge i_mclk);
  endtask : go

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    {i_rst, i_latch_option, i_read_sel, i_read_bit} = 7'h40;
    {i_status, i_codes} = '0;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    foreach (rows[r]) begin
      go(rows[r].k, rows[r].d, 1);
      chk("service", 16'(rows[r].svc), 16'(o_service));
      chk("trip_fault", 16'(rows[r].tf), 16'({o_test_trip, o_fault_reset}));
      chk("run", 16'(rows[r].run), 16'({o_remote, o_run2, o_run1}));
      chk("field", 16'(rows[r].fo), 16'(o_field_out));
    end
    i_latch_option = 1'b1;
    go(2'h2, 16'h0004, 3);
    chk("latch_set", 16'h0004, 16'(o_field_out));
    go(2'h2, 16'h0003, 3);
    chk("latch_hold", 16'h0007, 16'(o_field_out));
    go(2'h2, 16'h0008, 3);
    chk("latch_clear", 16'h0000, 16'(o_field_out));
    go(2'h3, 16'h001A, 3);
    chk("latch_both", 16'h0000, 16'(o_field_out));
    go(2'h3, 16'h000B, 3);
    chk("bit_latch", 16'h0004, 16'(o_field_out));
    go(2'h3, 16'h0010, 2);
    chk("bit_run", 16'h0001, 16'({o_remote, o_run2, o_run1}));
    go(2'h3, 16'h001C, 2);
    chk("bit_ignored", 16'h0011, 16'({o_field_out, o_run2, o_run1}));
    go(2'h3, 16'h0005, 1);
    chk("bit_trip_idle", 16'h0000, 16'(o_test_trip));
    go(2'h3, 16'h0015, 1);
    chk("bit_trip", 16'h0001, 16'(o_test_trip));
    i_codes = 48'h3C3C_A55A_0F0F;
    for (int b = 0; b < 8; b++) begin
      i_status = fmcd_pkg::fmcd_status_t'(8'h01 << b);
      i_read_bit = 3'(b);
      i_read_sel = 2'(b % 4);
      @(negedge i_mclk);
      chk("status", 16'(8'h01 << b), 16'(o_status_byte));
      chk("bit", 16'h0001, 16'(o_read_bit));
      chk("word", (b % 4 == 0) ? 16'(i_status) : 16'(i_codes >> (16 * (b % 4 - 1))), o_read_word);
    end
    // Clock enable low: writes refused, all outputs frozen
    i_ce = 1'b0;
    i_status = fmcd_pkg::fmcd_status_t'(8'h00);
    go(2'h0, 16'h0000, 1);
    chk("ce_run", 16'h0001, 16'({o_remote, o_run2, o_run1}));
    chk("ce_status", 16'h0080, 16'(o_status_byte));
    chk("ce_word", 16'h3C3C, o_read_word);
    i_ce = 1'b1;
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk("reset", 16'h0000, 16'({o_run1, o_field_out, o_status_byte}));
    i_rst = 1'b0;
    go(2'h0, 16'h0001, 1);
    chk("after_reset", 16'h0001, 16'({o_remote, o_run2, o_run1}));
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
